// ===== verilog/wake_ready_defs.vh
// constants for the wake and readiness signalling block
`ifndef WAKE_READY_DEFS_VH
`define WAKE_READY_DEFS_VH
`define CLK_FREQ_HZ 100000000
`define FILTER_TIME_MS 500
`define FILTER_CYCLES 27'd50000001 // 500 ms plus one cycle at 100 MHz
`define ALERT_TIME_MS 1000
`define ALERT_CYCLES 27'd100000000 // 1 s at 100 MHz
`define CNT_WIDTH 27
`define ALERT_IDLE 1'b1
`define ST_OFF 2'h0
`define ST_AWAKE 2'h1
`define ST_SLEEP 2'h2
`endif

// ===== verilog/level_filter.v
// anti-bounce filter: output follows input after it stays stable for a full interval
`timescale 1ns/1ps
module level_filter #(
   parameter WIDTH = 27,
   parameter [WIDTH-1:0] STABLE_CYCLES = 27'd50000001
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // level in and filtered level out
   input wire level_in,
   output reg level_out
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge clk) begin
      if (rst) begin
         cnt_q <= {WIDTH{1'b0}};
         level_out <= 1'b0;
      end else if (level_in == level_out) begin
         cnt_q <= {WIDTH{1'b0}};
      end else if (cnt_q == STABLE_CYCLES - 1'b1) begin
         cnt_q <= {WIDTH{1'b0}};
         level_out <= level_in;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // level_filter

// ===== verilog/wake_ready.v
// power-state signalling: readiness output, wake request input, wake alert output
`timescale 1ns/1ps
`include "wake_ready_defs.vh"
module wake_ready #(
   parameter [`CNT_WIDTH-1:0] FILTER_CYCLES = `FILTER_CYCLES,
   parameter [`CNT_WIDTH-1:0] ALERT_CYCLES = `ALERT_CYCLES
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // module power state
   input wire power_good,
   input wire core_ready,
   // host wake request pin
   input wire wake_req,
   // wake source from the module core
   input wire wake_source,
   // outputs to host and core
   output reg ready_out,
   output reg wake_alert,
   output reg awake,
   output reg sleep_allowed
);
   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   localparam N_SYNC = 3;
   wire [N_SYNC-1:0] pin_raw;
   wire [N_SYNC-1:0] pin_sync;
   wire req_sync;
   wire pg_sync;
   wire cr_sync;
   genvar g;
   assign pin_raw = {core_ready, power_good, wake_req};
   generate
      for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
         reg s1_q;
         reg s2_q;
         always @(posedge clk) begin
            if (rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= pin_raw[g];
               s2_q <= s1_q;
            end
         end
         assign pin_sync[g] = s2_q;
      end
   endgenerate
   assign req_sync = pin_sync[0];
   assign pg_sync = pin_sync[1];
   assign cr_sync = pin_sync[2];

   // ---------------------------------------------
   // wake request filter
   // ---------------------------------------------
   wire req_filt;
   reg req_filt_q;
   level_filter #(
      .WIDTH(`CNT_WIDTH),
      .STABLE_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .clk(clk),
      .rst(rst),
      .level_in(req_sync),
      .level_out(req_filt)
   );

   // ---------------------------------------------
   // filtered level edges
   // ---------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         req_filt_q <= 1'b0;
      end else begin
         req_filt_q <= req_filt;
      end
   end
   wire req_rise = req_filt & ~req_filt_q;
   wire req_fall = ~req_filt & req_filt_q;

   // ---------------------------------------------
   // power qualification
   // ---------------------------------------------
   wire powered = pg_sync & cr_sync;

   // ---------------------------------------------
   // power state machine
   // ---------------------------------------------
   reg [1:0] state_q;
   reg [1:0] state_d;
   always @* begin
      state_d = state_q;
      case (state_q)
         `ST_OFF: begin
            if (powered) begin
               state_d = `ST_AWAKE;
            end
         end
         `ST_AWAKE: begin
            if (!powered) begin
               state_d = `ST_OFF;
            end else if (req_fall) begin
               state_d = `ST_SLEEP;
            end
         end
         `ST_SLEEP: begin
            if (!powered) begin
               state_d = `ST_OFF;
            end else if (req_rise) begin
               state_d = `ST_AWAKE;
            end
         end
         default: begin
            state_d = `ST_OFF;
         end
      endcase
   end

   // ---------------------------------------------
   // power state register
   // ---------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state_q <= `ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------
   // decoding functions
   // ---------------------------------------------
   function state_is;
      input [1:0] st;
      input [1:0] code;
      begin
         state_is = (st == code);
      end
   endfunction
   function cnt_is;
      input [`CNT_WIDTH-1:0] cnt;
      input [`CNT_WIDTH-1:0] value;
      begin
         cnt_is = (cnt == value);
      end
   endfunction

   // ---------------------------------------------
   // readiness output
   // ---------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= !state_is(state_d, `ST_OFF);
      end
   end

   // ---------------------------------------------
   // state flags
   // ---------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         awake <= 1'b0;
         sleep_allowed <= 1'b0;
      end else begin
         awake <= state_is(state_d, `ST_AWAKE);
         sleep_allowed <= state_is(state_d, `ST_SLEEP);
      end
   end

   // ---------------------------------------------
   // wake source arrival
   // ---------------------------------------------
   reg src_q;
   always @(posedge clk) begin
      if (rst) begin
         src_q <= 1'b0;
      end else begin
         src_q <= wake_source;
      end
   end
   wire src_arrive = wake_source & ~src_q;

   // ---------------------------------------------
   // wake alert pulse
   // ---------------------------------------------
   localparam [`CNT_WIDTH-1:0] CNT_ZERO = {`CNT_WIDTH{1'b0}};
   localparam [`CNT_WIDTH-1:0] CNT_ONE = {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
   reg [`CNT_WIDTH-1:0] alert_cnt_q;
   wire alert_busy = !cnt_is(alert_cnt_q, CNT_ZERO);
   wire alert_last = cnt_is(alert_cnt_q, CNT_ONE);
   wire alert_start = src_arrive && ready_out && !alert_busy;
   always @(posedge clk) begin
      if (rst) begin
         alert_cnt_q <= CNT_ZERO;
      end else if (alert_start) begin
         alert_cnt_q <= ALERT_CYCLES;
      end else if (alert_busy) begin
         alert_cnt_q <= alert_cnt_q - 1'b1;
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         wake_alert <= `ALERT_IDLE;
      end else if (alert_start) begin
         wake_alert <= ~`ALERT_IDLE;
      end else if (alert_last) begin
         wake_alert <= `ALERT_IDLE;
      end
   end
endmodule // wake_ready

// ===== verification/wake_ready_props.sv
// assertions on the ports of the wake and readiness block
`timescale 1ns/1ps
module wake_ready_props (
   // clock and reset
   input wire clk,
   input wire rst,
   // inputs of the block
   input wire power_good,
   input wire core_ready,
   input wire wake_req,
   input wire wake_source,
   // outputs of the block
   input wire ready_out,
   input wire wake_alert,
   input wire awake,
   input wire sleep_allowed
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_ready_rise: assert property (ready_out |-> $past(power_good && core_ready, 3))
      else $error("ready without power");
   chk_ready_low: assert property (!(power_good && core_ready) |-> ##3 !ready_out)
      else $error("ready while unpowered");
   chk_wake_rise: assert property ($rose(awake) && $past(sleep_allowed) |-> $past(wake_req, 12) && $past(wake_req, 20))
      else $error("wake without stable request");
   chk_sleep_fall: assert property ($rose(sleep_allowed) |-> !$past(wake_req, 12) && !$past(wake_req, 20))
      else $error("sleep without stable low");
   chk_alert_src: assert property ($fell(wake_alert) |-> $past(wake_source && ready_out) || $past(wake_source && ready_out, 2))
      else $error("alert without source");
   chk_alert_hold: assert property ($fell(wake_alert) |-> !wake_alert [*8])
      else $error("alert pulse short");
   chk_alert_end: assert property ($fell(wake_alert) |-> ##9 !wake_alert ##1 wake_alert)
      else $error("alert pulse length");
   chk_state_excl: assert property (!(awake && sleep_allowed))
      else $error("awake and sleep together");
endmodule // wake_ready_props
bind wake_ready wake_ready_props i_props (.clk(clk), .rst(rst), .power_good(power_good), .core_ready(core_ready),
   .wake_req(wake_req), .wake_source(wake_source), .ready_out(ready_out), .wake_alert(wake_alert),
   .awake(awake), .sleep_allowed(sleep_allowed));

// ===== verification/host_model.sv
// host side driver of the wake request pin
`timescale 1ns/1ps
module host_model (
   // clock and pin
   input wire clk,
   output reg wake_req
);
   initial wake_req = 1'b0;
   task hold(input logic lvl, input int n);
      @(posedge clk) #1 wake_req = lvl;
      repeat (n) @(posedge clk);
   endtask
endmodule // host_model

// ===== verification/testbench.sv
// self-checking bench for the wake and readiness block
`timescale 1ns/1ps
module testbench;
   localparam int F = 20;
   localparam int A = 10;
   logic clk, rst, power_good, core_ready, wake_source;
   wire wake_req, ready_out, wake_alert, awake, sleep_allowed;
   int n_errors = 0, n_compared = 0, seed = 32'h8f40, cyc = 0, w;
   wake_ready #(.FILTER_CYCLES(27'd20), .ALERT_CYCLES(27'd10)) i_dut (.clk(clk), .rst(rst),
      .power_good(power_good), .core_ready(core_ready), .wake_req(wake_req), .wake_source(wake_source),
      .ready_out(ready_out), .wake_alert(wake_alert), .awake(awake), .sleep_allowed(sleep_allowed));
   host_model i_host (.clk(clk), .wake_req(wake_req));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end
   function automatic logic passes(input int n);
      return n >= F;
   endfunction
   // source held k cycles gives one pulse of A cycles
   task alert(input int k);
      @(posedge clk) #1 wake_source = 1;
      w = 0;
      for (int i = 0; i < A + 6; i++) begin
         @(posedge clk) #1;
         if (i == k - 1) wake_source = 0;
         if (wake_alert === 1'b0) w++;
      end
      chk(w == A, 1'b1);
      chk(wake_alert, 1'b1);
   endtask
   initial begin
      rst = 1;
      power_good = 0;
      core_ready = 0;
      wake_source = 0;
      repeat (8) @(posedge clk);
      #1 rst = 0;
      chk(ready_out, 1'b0);
      chk(wake_alert, 1'b1);
      power_good = 1;
      core_ready = 1;
      repeat (5) @(posedge clk);
      #1 chk(ready_out, 1'b1);
      chk(awake, 1'b1);
      repeat (4) alert($unsigned($random(seed)) % 3 + 1);
      alert(A + 4);
      i_host.hold(1, F + 10);
      i_host.hold(0, F + 10);
      #1 chk(sleep_allowed, 1'b1);
      i_host.hold(1, 5);
      i_host.hold(0, F + 10);
      #1 chk(awake, 1'b0);
      i_host.hold(1, F - 2);
      i_host.hold(0, F + 10);
      #1 chk(awake, passes(F - 1));
      i_host.hold(1, F - 1);
      i_host.hold(0, 3);
      #1 chk(awake, passes(F));
      repeat (F + 10) @(posedge clk);
      #1 chk(sleep_allowed, 1'b1);
      i_host.hold(1, F + 10);
      #1 chk(awake, 1'b1);
      @(posedge clk) #1 rst = 1;
      repeat (2) @(posedge clk);
      #1 chk(ready_out, 1'b0);
      chk(wake_alert, 1'b1);
      rst = 0;
      repeat (4) @(posedge clk);
      #1 chk(ready_out, 1'b1);
      @(posedge clk) #1 power_good = 0;
      repeat (4) @(posedge clk);
      #1 chk(ready_out, 1'b0);
      wake_source = 1;
      @(posedge clk) #1 wake_source = 0;
      repeat (3) @(posedge clk);
      #1 chk(wake_alert, 1'b1);
      report_and_stop;
   end
endmodule // testbench
